// ### verilog/gtts_defines.svh
// register map, field positions and fixed values of the gate and trigger stamp block
`ifndef GTTS_DEFINES_SVH
`define GTTS_DEFINES_SVH

`define GTTS_AW              16
`define GTTS_ADDR_CMD        16'hB798
`define GTTS_ADDR_CTRL       16'hB7A0
`define GTTS_ADDR_PRE        16'hB7A4
`define GTTS_ADDR_POST       16'hB7A8
`define GTTS_ADDR_TOTAL      16'hB7AC
`define GTTS_ADDR_DIV        16'hB7B0
`define GTTS_ADDR_AVAIL      16'hB7B4
`define GTTS_ADDR_DLO        16'hB7B8
`define GTTS_ADDR_DHI        16'hB7BC
`define GTTS_ADDR_STAT       16'hB7C0

`define GTTS_CMD_RESET       32'h0000_0000
`define GTTS_CMD_MODE_MSB    3
`define GTTS_CMD_MODE_LSB    0
`define GTTS_TSMODE_OFF      4'h0
`define GTTS_FEAT_MASK       32'h000F_0000
`define GTTS_FEAT_FIRST_SLOW 32'h0001_0000
`define GTTS_FEAT_NONE       32'h0000_0000

`define GTTS_CTRL_START      0
`define GTTS_CTRL_STOP       1
`define GTTS_CTRL_MODE_LSB   2
`define GTTS_CTRL_MODE_MSB   3

`define GTTS_STAT_RUN        0
`define GTTS_STAT_OVF        1
`define GTTS_STAT_DONE       2

`define GTTS_CNT_W           56
`define GTTS_STAMP_W         64
`define GTTS_STAMP_PAD       8'h00
`define GTTS_BYTES_SHIFT     3

`define GTTS_DIV_SHIFT       3
`define GTTS_DIV_MIN_STEPS   16'h0001
`define GTTS_DIV_MAX_STEPS   16'hFFFF
`define GTTS_DIV_RESET       32'h0000_0008

`endif

// ### verilog/gtts_pkg.sv
// types shared by the gate and trigger stamp block
`default_nettype none
package gtts_pkg;
   typedef enum logic [1:0] {
      GTTS_ACQ_OFF   = 2'b00,
      GTTS_ACQ_GATED = 2'b01,
      GTTS_ACQ_DUAL  = 2'b10
   } gtts_acq_t;

   typedef enum logic [1:0] {
      GTTS_IDLE = 2'b00,
      GTTS_RUN  = 2'b01,
      GTTS_DONE = 2'b10
   } gtts_state_t;
endpackage : gtts_pkg
`default_nettype wire

// ### verilog/gtts_slow_div.sv
// slow sample clock tick: fast clock divided by a multiple of eight
`timescale 1ns/1ps
`default_nettype none
`include "gtts_defines.svh"
module gtts_slow_div import gtts_pkg::*; (
   // clock and reset
   input  wire logic        clk,
   input  wire logic        rstn,
   // control
   input  wire logic        restart,
   input  wire logic [15:0] steps,
   // tick, one cycle per slow sample
   output var  logic        tick
);
   logic [18:0] cnt_reg;
   logic [18:0] period_m1;

   // period is steps times eight fast samples
   assign period_m1 = {steps, 3'h0} - 19'h1;

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         cnt_reg <= 19'h0;
      end else if (restart || cnt_reg == 19'h0) begin
         cnt_reg <= period_m1;
      end else begin
         cnt_reg <= cnt_reg - 19'h1;
      end
   end

   // restart tick lands on the first slow sample after card start
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         tick <= 1'b0;
      end else begin
         tick <= restart || cnt_reg == 19'h0;
      end
   end

   chk_div_period: assert property (@(posedge clk) disable iff (!rstn)
      tick && !restart |-> cnt_reg == $past(period_m1))
      else $error("slow tick period does not follow the divider");
endmodule : gtts_slow_div
`default_nettype wire

// ### verilog/gtts_top.sv
// gate and trigger timestamp capture with host stamp read-out
// Overview of operation
// - with stamps on in gated mode, stamp each gate opening and closing
// - gate stamps come in pairs: start position, then end position
// - stamps mark gate edges; first sample is start stamp minus pre count
// - segment length is end minus start plus padding, pre and post counts
// - last sample lies at end stamp plus padding plus post count
// - standard gated recording ends when total sample count expires
// - limit reached inside a gate emits one extra closing stamp
// - every stamp is 64 bits, eight bytes of the stream
// - in dual timebase mode every cycle with trigger high gets one stamp
// - first fast sample of a segment is trigger stamp minus pre count
// - first slow sample is tied to card start at a fixed offset
// - timestamp command register is read/write and selects mode and features
// - feature bits live in the feature mask field of the command
// - first slow sample feature stores one extra stamp in fast timebase
// - feature field zero means no extra stamp, only event stamps
// - the first slow sample feature works with every stamp mode
// - the stamp counter advances on the fast sample clock
// - slow clock is fast clock over divider 8 to 524280, steps of 8
// - stamp value is a 56-bit count in the low seven bytes
`timescale 1ns/1ps
`default_nettype none
`include "gtts_defines.svh"
module gtts_top import gtts_pkg::*; #(
   parameter int DEPTH = 16,
   parameter int ALIGN = 4
) (
   // clock and reset
   input  wire logic                 CLOCK,
   input  wire logic                 RSTN,
   // register port
   input  wire logic [`GTTS_AW-1:0]  ADDR,
   input  wire logic [31:0]          WDATA,
   input  wire logic                 WR,
   input  wire logic                 RD,
   output var  logic [31:0]          RDATA,
   // acquisition events
   input  wire logic                 GATE,
   input  wire logic                 TRIGGER,
   // slow sample tick
   output logic                      SLOW_SAMPLE
);
   localparam int PW = $clog2(DEPTH);
   localparam logic [31:0] ALIGN_MASK = 32'(ALIGN - 1);

   logic [31:0]              cmd_reg;
   gtts_acq_t                acq_reg;
   gtts_state_t              state_reg;
   logic [31:0]              pre_reg;
   logic [31:0]              post_reg;
   logic [31:0]              total_reg;
   logic [15:0]              div_reg;
   logic [`GTTS_CNT_W-1:0]   cnt_reg;
   logic [31:0]              remain_reg;
   logic [31:0]              remain_next;
   logic [31:0]              glen_reg;
   logic                     gate_d_reg;
   logic                     ovf_reg;
   logic                     slow_pend_reg;
   logic                     slow_ready_reg;
   logic [`GTTS_CNT_W-1:0]   slow_val_reg;
   logic [`GTTS_STAMP_W-1:0] mem [DEPTH];
   logic [PW-1:0]            wptr_reg;
   logic [PW-1:0]            rptr_reg;
   logic [PW:0]              fill_reg;

   logic start_w, stop_w, ts_on, running, gated, dual, in_gate;
   logic gate_rise_w, gate_fall_w, trig_w, limit_w, finish_w, main_ev;
   logic wr_en_w, push_w, pop_w, full_w, empty_w;
   logic [`GTTS_STAMP_W-1:0] wr_data_w;
   logic [31:0] pad_w;

   function automatic logic [31:0] sat_sub(input logic [31:0] a, input logic [31:0] b);
      sat_sub = (a > b) ? a - b : 32'h0;
   endfunction : sat_sub

   assign start_w = WR && ADDR == `GTTS_ADDR_CTRL && WDATA[`GTTS_CTRL_START];
   assign stop_w  = WR && ADDR == `GTTS_ADDR_CTRL && WDATA[`GTTS_CTRL_STOP];
   assign ts_on   = cmd_reg[`GTTS_CMD_MODE_MSB:`GTTS_CMD_MODE_LSB] != `GTTS_TSMODE_OFF;
   assign running = state_reg == GTTS_RUN;
   assign gated   = acq_reg == GTTS_ACQ_GATED;
   assign dual    = acq_reg == GTTS_ACQ_DUAL;
   assign in_gate = gate_d_reg && GATE;

   // stamps mark the gate edges themselves, not the stored window
   assign gate_rise_w = running && gated && ts_on && GATE && !gate_d_reg;
   assign gate_fall_w = running && gated && ts_on && !GATE && gate_d_reg;
   assign trig_w      = running && dual && ts_on && TRIGGER;

   // padding rounds the gate length up to the next alignment boundary
   assign pad_w = ALIGN_MASK & (32'h0 - (glen_reg + 32'h1));

   always_comb begin
      remain_next = remain_reg;
      if (running && gated) begin
         if (GATE && !gate_d_reg) begin
            remain_next = sat_sub(remain_reg, pre_reg);
         end else if (!GATE && gate_d_reg) begin
            remain_next = sat_sub(remain_reg, post_reg + pad_w);
         end else if (in_gate) begin
            remain_next = sat_sub(remain_reg, 32'h1);
         end
      end
   end

   // memory running out inside a gate closes that segment with a stamp
   assign limit_w  = running && gated && in_gate && remain_next == 32'h0;
   assign finish_w = limit_w || (running && gated && gate_d_reg && !GATE
                                 && remain_next == 32'h0);

   // one write per cycle; a late slow stamp waits behind an event stamp
   assign main_ev   = gate_rise_w || gate_fall_w || trig_w || (limit_w && ts_on);
   assign wr_en_w   = main_ev || slow_ready_reg;
   assign wr_data_w = main_ev ? {`GTTS_STAMP_PAD, cnt_reg}
                              : {`GTTS_STAMP_PAD, slow_val_reg};

   assign full_w  = fill_reg == (PW+1)'(DEPTH);
   assign empty_w = fill_reg == '0;
   assign push_w  = wr_en_w && !full_w;
   assign pop_w   = RD && ADDR == `GTTS_ADDR_DHI && !empty_w;

   // register writes
   always_ff @(posedge CLOCK or negedge RSTN) begin
      if (!RSTN) begin
         cmd_reg   <= `GTTS_CMD_RESET;
         acq_reg   <= GTTS_ACQ_OFF;
         pre_reg   <= 32'h0;
         post_reg  <= 32'h0;
         total_reg <= 32'h0;
         div_reg   <= `GTTS_DIV_MIN_STEPS;
      end else if (WR) begin
         unique case (ADDR)
            `GTTS_ADDR_CMD: cmd_reg <= WDATA;
            `GTTS_ADDR_CTRL: begin
               if (WDATA[`GTTS_CTRL_MODE_MSB:`GTTS_CTRL_MODE_LSB] != GTTS_ACQ_OFF + 2'h3) begin
                  acq_reg <= gtts_acq_t'(WDATA[`GTTS_CTRL_MODE_MSB:`GTTS_CTRL_MODE_LSB]);
               end
            end
            `GTTS_ADDR_PRE:   pre_reg   <= WDATA;
            `GTTS_ADDR_POST:  post_reg  <= WDATA;
            `GTTS_ADDR_TOTAL: total_reg <= WDATA;
            `GTTS_ADDR_DIV: begin
               // out-of-range divider values clamp to the nearest legal one
               if (WDATA[31:19] != 13'h0) begin
                  div_reg <= `GTTS_DIV_MAX_STEPS;
               end else if (WDATA[18:`GTTS_DIV_SHIFT] == 16'h0) begin
                  div_reg <= `GTTS_DIV_MIN_STEPS;
               end else begin
                  div_reg <= WDATA[18:`GTTS_DIV_SHIFT];
               end
            end
            default: ;
         endcase
      end
   end

   // acquisition sequence
   always_ff @(posedge CLOCK or negedge RSTN) begin
      if (!RSTN) begin
         state_reg <= GTTS_IDLE;
      end else if (start_w) begin
         state_reg <= GTTS_RUN;
      end else if (stop_w && running) begin
         state_reg <= GTTS_IDLE;
      end else if (finish_w) begin
         state_reg <= GTTS_DONE;
      end
   end

   // stamp counter on the fast sample clock, cleared by card start
   always_ff @(posedge CLOCK or negedge RSTN) begin
      if (!RSTN) begin
         cnt_reg <= '0;
      end else if (start_w) begin
         cnt_reg <= '0;
      end else begin
         cnt_reg <= cnt_reg + `GTTS_CNT_W'(1);
      end
   end

   // sample budget and gate length tracking
   always_ff @(posedge CLOCK or negedge RSTN) begin
      if (!RSTN) begin
         remain_reg <= 32'h0;
         glen_reg   <= 32'h0;
         gate_d_reg <= 1'b0;
      end else begin
         gate_d_reg <= GATE;
         remain_reg <= start_w ? total_reg : remain_next;
         if (GATE && !gate_d_reg) begin
            glen_reg <= 32'h0;
         end else if (in_gate) begin
            glen_reg <= glen_reg + 32'h1;
         end
      end
   end

   // first slow sample after card start, stamped in the fast timebase
   always_ff @(posedge CLOCK or negedge RSTN) begin
      if (!RSTN) begin
         slow_pend_reg  <= 1'b0;
         slow_ready_reg <= 1'b0;
         slow_val_reg   <= '0;
      end else if (start_w) begin
         // armed from the command word in force at card start
         slow_pend_reg  <= (cmd_reg & `GTTS_FEAT_MASK) == `GTTS_FEAT_FIRST_SLOW;
         slow_ready_reg <= 1'b0;
      end else begin
         if (slow_pend_reg && SLOW_SAMPLE && running) begin
            slow_pend_reg  <= 1'b0;
            slow_ready_reg <= 1'b1;
            slow_val_reg   <= cnt_reg;
         end else if (slow_ready_reg && !main_ev) begin
            slow_ready_reg <= 1'b0;
         end
      end
   end

   // stamp store; a full store drops the stamp and flags it
   always_ff @(posedge CLOCK) begin
      if (push_w) begin
         mem[wptr_reg] <= wr_data_w;
      end
   end

   always_ff @(posedge CLOCK or negedge RSTN) begin
      if (!RSTN) begin
         wptr_reg <= '0;
         rptr_reg <= '0;
         fill_reg <= '0;
      end else begin
         if (push_w) begin
            wptr_reg <= PW'(wptr_reg + 1'b1);
         end
         if (pop_w) begin
            rptr_reg <= PW'(rptr_reg + 1'b1);
         end
         fill_reg <= fill_reg + (PW+1)'(push_w) - (PW+1)'(pop_w);
      end
   end

   // overflow set wins over the clear by card start
   always_ff @(posedge CLOCK or negedge RSTN) begin
      if (!RSTN) begin
         ovf_reg <= 1'b0;
      end else if (wr_en_w && full_w) begin
         ovf_reg <= 1'b1;
      end else if (start_w) begin
         ovf_reg <= 1'b0;
      end
   end

   // read data one cycle after the strobe, zero elsewhere
   always_ff @(posedge CLOCK or negedge RSTN) begin
      if (!RSTN) begin
         RDATA <= 32'h0;
      end else if (RD) begin
         unique case (ADDR)
            `GTTS_ADDR_CMD:   RDATA <= cmd_reg;
            `GTTS_ADDR_CTRL:  RDATA <= {28'h0, acq_reg, 2'h0};
            `GTTS_ADDR_PRE:   RDATA <= pre_reg;
            `GTTS_ADDR_POST:  RDATA <= post_reg;
            `GTTS_ADDR_TOTAL: RDATA <= total_reg;
            `GTTS_ADDR_DIV:   RDATA <= {13'h0, div_reg, 3'h0};
            `GTTS_ADDR_AVAIL: RDATA <= 32'(fill_reg) << `GTTS_BYTES_SHIFT;
            `GTTS_ADDR_DLO:   RDATA <= empty_w ? 32'h0 : mem[rptr_reg][31:0];
            `GTTS_ADDR_DHI:   RDATA <= empty_w ? 32'h0 : mem[rptr_reg][63:32];
            `GTTS_ADDR_STAT:  RDATA <= {29'h0, state_reg == GTTS_DONE, ovf_reg, running};
            default:          RDATA <= 32'h0;
         endcase
      end else begin
         RDATA <= 32'h0;
      end
   end

   gtts_slow_div u_slow_div (
      .clk     (CLOCK),
      .rstn    (RSTN),
      .restart (start_w),
      .steps   (div_reg),
      .tick    (SLOW_SAMPLE)
   );

   chk_gate_open_stamp: assert property (@(posedge CLOCK) disable iff (!RSTN)
      gate_rise_w && !full_w |=> fill_reg != '0)
      else $error("gate opening left no stamp");
   chk_gate_pair_end: assert property (@(posedge CLOCK) disable iff (!RSTN)
      gate_fall_w |-> wr_en_w && wr_data_w[`GTTS_CNT_W-1:0] == cnt_reg)
      else $error("gate closing stamp missing or wrong");
   chk_limit_close: assert property (@(posedge CLOCK) disable iff (!RSTN)
      limit_w && ts_on && !start_w |-> wr_en_w ##1 state_reg == GTTS_DONE)
      else $error("limit inside gate did not close the segment");
   chk_budget_end: assert property (@(posedge CLOCK) disable iff (!RSTN)
      running && gated && remain_reg == 32'h0 |-> gate_d_reg)
      else $error("recording ran on with no samples left");
   chk_trigger_stamp: assert property (@(posedge CLOCK) disable iff (!RSTN)
      trig_w |-> wr_en_w && wr_data_w == {`GTTS_STAMP_PAD, cnt_reg})
      else $error("trigger not stamped with current count");
   chk_upper_byte: assert property (@(posedge CLOCK) disable iff (!RSTN)
      wr_en_w |-> wr_data_w[63:56] == `GTTS_STAMP_PAD)
      else $error("stamp upper byte not zero");
   chk_fast_count: assert property (@(posedge CLOCK) disable iff (!RSTN)
      RSTN && !start_w |=> cnt_reg == $past(cnt_reg) + `GTTS_CNT_W'(1))
      else $error("stamp counter did not advance each fast cycle");
   chk_no_extra: assert property (@(posedge CLOCK) disable iff (!RSTN)
      start_w && (cmd_reg & `GTTS_FEAT_MASK) == `GTTS_FEAT_NONE |=> !slow_pend_reg)
      else $error("extra stamp armed with feature field zero");
   chk_slow_order: assert property (@(posedge CLOCK) disable iff (!RSTN)
      slow_ready_reg && main_ev && !start_w |=> slow_ready_reg)
      else $error("slow stamp lost behind an event stamp");
   chk_avail_pop: assert property (@(posedge CLOCK) disable iff (!RSTN)
      pop_w && !push_w |=> fill_reg == $past(fill_reg) - 1'b1)
      else $error("available count not reduced by a read");

   cov_gate_pair: cover property (@(posedge CLOCK) disable iff (!RSTN)
      gate_rise_w ##[1:50] gate_fall_w);
   cov_limit: cover property (@(posedge CLOCK) disable iff (!RSTN) limit_w && ts_on);
   cov_slow_stamp: cover property (@(posedge CLOCK) disable iff (!RSTN)
      slow_ready_reg && !main_ev);
   cov_overflow: cover property (@(posedge CLOCK) disable iff (!RSTN) wr_en_w && full_w);
endmodule : gtts_top
`default_nettype wire

// ### verif/gtts_host_model.sv
// host side model: register port master that reads the stamp stream
`timescale 1ns/1ps
`default_nettype none
`include "gtts_defines.svh"
module gtts_host_model (
   // clock
   input  wire logic                clk,
   // register port
   output var  logic [`GTTS_AW-1:0] addr,
   output var  logic [31:0]         wdata,
   output var  logic                wr,
   output var  logic                rd,
   input  wire logic [31:0]         rdata
);
   initial begin
      addr  = '0;
      wdata = '0;
      wr    = 1'b0;
      rd    = 1'b0;
   end

   task automatic wr_reg(input logic [`GTTS_AW-1:0] a, input logic [31:0] d);
      @(posedge clk);
      addr  <= a;
      wdata <= d;
      wr    <= 1'b1;
      @(posedge clk);
      wr    <= 1'b0;
   endtask : wr_reg

   // read data stand only in the cycle after the strobe, so sample just past that edge
   task automatic rd_reg(input logic [`GTTS_AW-1:0] a, output logic [31:0] d);
      @(posedge clk);
      addr <= a;
      rd   <= 1'b1;
      @(posedge clk);
      rd   <= 1'b0;
      #1;
      d = rdata;
   endtask : rd_reg

   // low word first: only the high word read pops the stamp
   task automatic rd_stamp(output logic [63:0] s);
      logic [31:0] lo;
      logic [31:0] hi;
      rd_reg(`GTTS_ADDR_DLO, lo);
      rd_reg(`GTTS_ADDR_DHI, hi);
      s = {hi, lo};
   endtask : rd_stamp
endmodule : gtts_host_model
`default_nettype wire

// ### verif/gtts_top_test.sv
// self-checking bench for the gate and trigger stamp block
`timescale 1ns/1ps
`default_nettype none
`include "gtts_defines.svh"
module gtts_top_test import gtts_pkg::*;;
   localparam int DEPTH = 16;
   logic                clock = 1'b0;
   logic                rstn  = 1'b0;
   logic                gate  = 1'b0;
   logic                trig  = 1'b0;
   logic [`GTTS_AW-1:0] addr;
   logic [31:0]         wdata;
   logic [31:0]         rdata;
   logic                wr;
   logic                rd;
   logic                slow;
   int                  miscompares = 0;
   int                  comparisons = 0;
   int                  cycles      = 0;
   int                  gap         = 0;
   int                  since       = 0;
   logic [31:0]         seed        = 32'h0000_005D;
   // behavioural model state
   longint              m_cnt  = 0;
   logic                m_run  = 1'b0;
   logic                m_gq   = 1'b0;
   logic                m_arm  = 1'b0;
   logic                m_ovf  = 1'b0;
   logic [1:0]          m_mode = 2'h0;
   logic [31:0]         m_cmd  = 32'h0;
   logic [63:0]         m_q[$];
   logic [31:0]         div_in [4] = '{32'h0000_0004, 32'h0007_FFFF, 32'h000F_4240,
                                       32'h0000_0010};
   logic [31:0]         div_ex [4] = '{32'h0000_0008, 32'h0007_FFF8, 32'h0007_FFF8,
                                       32'h0000_0010};

   always #25 clock = ~clock;

   gtts_top #(.DEPTH(DEPTH), .ALIGN(4)) u_dut (.CLOCK(clock), .RSTN(rstn), .ADDR(addr),
      .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata), .GATE(gate), .TRIGGER(trig),
      .SLOW_SAMPLE(slow));
   gtts_host_model u_host (.clk(clock), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
      .rdata(rdata));

   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : rnd

   task automatic push(input longint v);
      if (m_q.size() < DEPTH) begin
         m_q.push_back(64'(v));
      end else begin
         m_ovf = 1'b1;
      end
   endtask : push

   // event stamps go in before a slow stamp of the same cycle
   always @(posedge clock) begin
      if (m_run && m_cmd[3:0] != 4'h0) begin
         if (m_mode == 2'h1 && gate != m_gq) push(m_cnt);
         if (m_mode == 2'h2 && trig) push(m_cnt);
      end
      if (m_arm && slow) begin
         push(m_cnt);
         m_arm = 1'b0;
      end
      m_gq = gate;
      m_cnt++;
      if (wr && addr == `GTTS_ADDR_CMD) m_cmd = wdata;
      if (wr && addr == `GTTS_ADDR_CTRL && wdata[`GTTS_CTRL_START]) begin
         m_run  = 1'b1;
         m_cnt  = 0;
         m_ovf  = 1'b0;
         m_mode = wdata[`GTTS_CTRL_MODE_MSB:`GTTS_CTRL_MODE_LSB];
         m_arm  = (m_cmd & `GTTS_FEAT_MASK) == `GTTS_FEAT_FIRST_SLOW;
      end
      if (wr && addr == `GTTS_ADDR_CTRL && wdata[`GTTS_CTRL_STOP]) m_run = 1'b0;
   end

   always @(posedge clock) begin
      cycles++;
      if (slow) begin
         gap   = since;
         since = 1;
      end else begin
         since++;
      end
      if (cycles == 20000) begin
         miscompares++;
         $display("[ERR] %0t: run did not finish in time", $time);
         give_verdict();
      end
   end

   task automatic check(input logic [63:0] got, input logic [63:0] exp);
      comparisons++;
      if (got !== exp) begin
         miscompares++;
         $display("[ERR] %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check

   task automatic chk_rd(input logic [`GTTS_AW-1:0] a, input logic [31:0] e);
      logic [31:0] d;
      u_host.rd_reg(a, d);
      check(64'(d), 64'(e));
   endtask : chk_rd

   task automatic drain();
      logic [63:0] s;
      chk_rd(`GTTS_ADDR_AVAIL, 32'(m_q.size() * 8));
      while (m_q.size() > 0) begin
         u_host.rd_stamp(s);
         check(s, m_q.pop_front());
      end
      chk_rd(`GTTS_ADDR_DHI, 32'h0);
   endtask : drain

   // sel low drives the gate, high the trigger; gaps of at least one cycle
   task automatic pulse(input logic sel, input int hi, input int lo);
      if (sel) trig <= 1'b1;
      else gate <= 1'b1;
      repeat (hi) @(posedge clock);
      gate <= 1'b0;
      trig <= 1'b0;
      repeat (lo) @(posedge clock);
   endtask : pulse

   task automatic run(input logic [31:0] cmd, input logic [31:0] ctrl);
      u_host.wr_reg(`GTTS_ADDR_CMD, cmd);
      u_host.wr_reg(`GTTS_ADDR_CTRL, ctrl);
      repeat (3) @(posedge clock);
   endtask : run

   task automatic end_test(input string name);
      $display("test %s finished", name);
   endtask : end_test

   task automatic give_verdict();
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : give_verdict

   initial begin
      logic [31:0] v;
      logic [63:0] s;
      repeat (10) @(posedge clock);
      rstn <= 1'b1;
      chk_rd(`GTTS_ADDR_CMD, `GTTS_CMD_RESET);
      chk_rd(`GTTS_ADDR_DIV, `GTTS_DIV_RESET);
      chk_rd(`GTTS_ADDR_AVAIL, 32'h0);
      chk_rd(16'h0000, 32'h0);
      v = rnd();
      u_host.wr_reg(`GTTS_ADDR_CMD, v);
      chk_rd(`GTTS_ADDR_CMD, v);
      foreach (div_in[i]) begin
         u_host.wr_reg(`GTTS_ADDR_DIV, div_in[i]);
         chk_rd(`GTTS_ADDR_DIV, div_ex[i]);
      end
      end_test("registers");
      u_host.wr_reg(`GTTS_ADDR_PRE, 32'h2);
      u_host.wr_reg(`GTTS_ADDR_POST, 32'h3);
      u_host.wr_reg(`GTTS_ADDR_TOTAL, 32'hFFFF);
      run(`GTTS_FEAT_FIRST_SLOW | 32'h1, 32'h5);
      repeat (4) pulse(1'b0, 1 + rnd() % 6, 1 + rnd() % 6);
      u_host.wr_reg(`GTTS_ADDR_CTRL, 32'h2);
      drain();
      end_test("gated");
      run(32'h1, 32'h1);
      pulse(1'b0, 3, 2);
      pulse(1'b1, 2, 2);
      u_host.wr_reg(`GTTS_ADDR_CTRL, 32'h2);
      drain();
      end_test("off");
      run(`GTTS_FEAT_NONE | 32'h1, 32'h9);
      pulse(1'b1, 18, 40);
      check(64'(gap), 64'h10);
      chk_rd(`GTTS_ADDR_STAT, {30'h0, m_ovf, 1'b1});
      u_host.wr_reg(`GTTS_ADDR_CTRL, 32'h2);
      drain();
      end_test("dual overflow");
      run(`GTTS_FEAT_FIRST_SLOW | 32'h1, 32'h9);
      repeat (6) pulse(1'b1, 1 + rnd() % 3, 1 + rnd() % 7);
      u_host.wr_reg(`GTTS_ADDR_CTRL, 32'h2);
      drain();
      end_test("dual first slow");
      u_host.wr_reg(`GTTS_ADDR_POST, 32'h0);
      u_host.wr_reg(`GTTS_ADDR_TOTAL, 32'hC);
      run(32'h1, 32'h5);
      pulse(1'b0, 30, 3);
      chk_rd(`GTTS_ADDR_STAT, 32'h4);
      chk_rd(`GTTS_ADDR_AVAIL, 32'h10);
      u_host.rd_stamp(s);
      check(s, m_q[0]);
      u_host.rd_stamp(s);
      check(s - m_q[0], 64'(32'hC - 32'h2));
      m_q.delete();
      end_test("budget");
      give_verdict();
   end
endmodule : gtts_top_test
`default_nettype wire
